// ---- common/rms_pkg.sv ----
// package: constants, types and decode helpers for the reset mode strap latch
package rms_pkg;

	// ------------------------------------------------------------
	// register port and map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] REG_MISC = 8'h01;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h02;
	localparam logic [ADDR_W-1:0] REG_ID = 8'h03;
	localparam logic [DATA_W-1:0] BLOCK_ID = 8'h5a; // arbitrary value
	localparam int MISC_FLASH_BIT = 0;
	localparam int ST_OSC_BIT = 0;
	localparam int ST_DBG_BIT = 1;
	localparam int ST_VALID_BIT = 2;
	localparam int ST_PERIPH_BIT = 3;
	localparam int ST_LOCK_BIT = 4;

	// ------------------------------------------------------------
	// operating modes, encoded as top-middle-bottom levels
	// ------------------------------------------------------------
	localparam int MODE_W = 3;
	localparam logic [MODE_W-1:0] MODE_SPECIAL_SINGLE = 3'h0;
	localparam logic [MODE_W-1:0] MODE_EMUL_NARROW = 3'h1;
	localparam logic [MODE_W-1:0] MODE_SPECIAL_TEST = 3'h2;
	localparam logic [MODE_W-1:0] MODE_EMUL_WIDE = 3'h3;
	localparam logic [MODE_W-1:0] MODE_NORMAL_SINGLE = 3'h4;
	localparam logic [MODE_W-1:0] MODE_NORMAL_NARROW = 3'h5;
	localparam logic [MODE_W-1:0] MODE_PERIPHERAL = 3'h6;
	localparam logic [MODE_W-1:0] MODE_NORMAL_WIDE = 3'h7;
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic FLASH_VIS_RST = 1'b0;

	// ------------------------------------------------------------
	// flash window in the cpu address space
	// ------------------------------------------------------------
	localparam logic [15:0] FLASH_BASE = 16'h4000;
	localparam logic [15:0] FLASH_LAST = 16'hffff;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic top;
		logic middle;
		logic bottom;
		logic flash;
		logic osc;
	} rms_strap_t;

	typedef enum logic {CAP_ARMED, CAP_DONE} rms_cap_state_t;
	typedef enum logic {DBG_IDLE, DBG_ACTIVE} rms_dbg_state_t;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// flash-visible value for a mode and a strap level
	function automatic logic rms_flash_decode(input logic [MODE_W-1:0] mode, input logic strap);
		case (mode)
			MODE_SPECIAL_SINGLE, MODE_NORMAL_SINGLE, MODE_PERIPHERAL: rms_flash_decode = 1'b1;
			MODE_SPECIAL_TEST: rms_flash_decode = 1'b0;
			MODE_EMUL_NARROW, MODE_EMUL_WIDE: rms_flash_decode = ~strap;
			default: rms_flash_decode = strap;
		endcase
	endfunction : rms_flash_decode

	// special modes have the top level low
	function automatic logic rms_is_special(input logic [MODE_W-1:0] mode);
		rms_is_special = ~mode[MODE_W-1];
	endfunction : rms_is_special

endpackage : rms_pkg

// ---- core/rms_strap_capture.sv ----
// strap capture: samples the strap pins once at reset release
`timescale 1ns/1ps
module rms_strap_capture
	import rms_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// strap levels
	input wire rms_strap_t strap_in,
	// captured values
	output rms_strap_t strap_q,
	output logic cap_pulse,
	// pin pull-downs
	output logic pulldown_en
);

	rms_cap_state_t state;
	rms_cap_state_t next_state;
	rms_strap_t next_strap_q;
	logic next_cap_pulse;
	rms_strap_t strap_s;
	rms_strap_t next_strap_s;

	// pull-downs live exactly as long as reset is low
	assign pulldown_en = ~nrst;

	// track the pins while reset is low, so the last sample is the level at release
	always_comb begin
		next_strap_s = nrst ? strap_s : strap_in;
	end

	// no reset here: it has to keep sampling while reset is held
	always_ff @(posedge clk) begin
		strap_s <= next_strap_s;
	end

	// take the levels seen at the last edge in reset, while pull-downs still act
	always_comb begin
		next_state = state;
		next_strap_q = strap_q;
		next_cap_pulse = 1'b0;
		case (state)
			CAP_ARMED: begin
				next_strap_q = strap_s;
				next_cap_pulse = 1'b1;
				next_state = CAP_DONE;
			end
			CAP_DONE: next_state = CAP_DONE;
			default: next_state = CAP_ARMED;
		endcase
	end

	// capture registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= CAP_ARMED;
			strap_q <= '0;
			cap_pulse <= 1'b0;
		end else begin
			state <= next_state;
			strap_q <= next_strap_q;
			cap_pulse <= next_cap_pulse;
		end
	end

endmodule : rms_strap_capture

// ---- core/rms_mode_decode.sv ----
// mode decoder: turns captured straps into mode and flash visibility
`timescale 1ns/1ps
module rms_mode_decode
	import rms_pkg::*;
(
	// captured straps
	input wire rms_strap_t strap_q,
	// decoded configuration
	output logic [MODE_W-1:0] dec_mode,
	output logic dec_flash,
	output logic dec_dbg_active,
	output logic dec_periph
);

	// mode bits are the three levels, top first
	assign dec_mode = {strap_q.top, strap_q.middle, strap_q.bottom};

	// flash visibility per mode
	assign dec_flash = rms_flash_decode(dec_mode, strap_q.flash);

	// monitor comes up active only in special single-chip
	assign dec_dbg_active = (dec_mode == MODE_SPECIAL_SINGLE);

	// forbidden strapping, reported only
	assign dec_periph = (dec_mode == MODE_PERIPHERAL);

endmodule : rms_mode_decode

// ---- core/rms_strap_latch.sv ----
// reset mode strap latch: captures configuration and serves it to software
`timescale 1ns/1ps
module rms_strap_latch
	import rms_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,

	// strap pins
	input wire logic mode_select_top,
	input wire logic mode_select_middle,
	input wire logic mode_select_bottom,
	input wire logic flash_map_strap,
	input wire logic oscillator_select_strap,

	// pull-down controls for middle and bottom pins
	output logic pulldown_middle_en,
	output logic pulldown_bottom_en,

	// debug monitor
	input wire logic debug_activate_cmd,
	output logic debug_active,

	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,

	// configuration outputs
	output logic [MODE_W-1:0] op_mode,
	output logic flash_visible,
	output logic osc_colpitts_sel,
	output logic config_valid,

	// flash mapping
	input wire logic [15:0] cpu_addr,
	output logic flash_select
);

	// ------------------------------------------------------------
	// capture and decode
	// ------------------------------------------------------------
	rms_strap_t strap_in;
	rms_strap_t strap_q;
	logic cap_pulse;
	logic pulldown_en;
	logic [MODE_W-1:0] dec_mode;
	logic dec_flash;
	logic dec_dbg_active;
	logic dec_periph;

	// pack pins into one carrier
	assign strap_in.top = mode_select_top;
	assign strap_in.middle = mode_select_middle;
	assign strap_in.bottom = mode_select_bottom;
	assign strap_in.flash = flash_map_strap;
	assign strap_in.osc = oscillator_select_strap;

	rms_strap_capture u_capture (
		.clk(clk),
		.nrst(nrst),
		.strap_in(strap_in),
		.strap_q(strap_q),
		.cap_pulse(cap_pulse),
		.pulldown_en(pulldown_en)
	);

	rms_mode_decode u_decode (
		.strap_q(strap_q),
		.dec_mode(dec_mode),
		.dec_flash(dec_flash),
		.dec_dbg_active(dec_dbg_active),
		.dec_periph(dec_periph)
	);

	// both pins share the reset-only pull-down
	assign pulldown_middle_en = pulldown_en;
	assign pulldown_bottom_en = pulldown_en;

	// ------------------------------------------------------------
	// configuration state
	// ------------------------------------------------------------
	logic periph_seen;
	logic mode_lock;
	logic next_config_valid;
	logic [MODE_W-1:0] next_op_mode;
	logic next_flash_visible;
	logic next_osc_colpitts_sel;
	logic next_periph_seen;
	logic next_mode_lock;
	logic wr_mode;
	logic wr_misc;
	logic mode_ok;

	// software writes steer mode and flash map
	assign wr_mode = reg_wr && (reg_addr == REG_MODE) && config_valid;
	assign wr_misc = reg_wr && (reg_addr == REG_MISC) && config_valid;

	// special modes may go anywhere but peripheral; normal single once to expanded
	always_comb begin
		mode_ok = 1'b0;
		if (rms_is_special(op_mode)) begin
			mode_ok = (reg_wdata[MODE_W-1:0] != MODE_PERIPHERAL);
		end else if (!mode_lock && op_mode == MODE_NORMAL_SINGLE) begin
			mode_ok = (reg_wdata[MODE_W-1:0] == MODE_NORMAL_NARROW) ||
				(reg_wdata[MODE_W-1:0] == MODE_NORMAL_WIDE);
		end
	end

	// next configuration values
	always_comb begin
		next_config_valid = config_valid;
		next_op_mode = op_mode;
		next_flash_visible = flash_visible;
		next_osc_colpitts_sel = osc_colpitts_sel;
		next_periph_seen = periph_seen;
		next_mode_lock = mode_lock;
		if (cap_pulse) begin
			next_config_valid = 1'b1;
			next_op_mode = dec_mode;
			next_flash_visible = dec_flash;
			next_osc_colpitts_sel = strap_q.osc;
			next_periph_seen = dec_periph;
		end else begin
			if (wr_mode && mode_ok) begin
				next_op_mode = reg_wdata[MODE_W-1:0];
				next_mode_lock = ~rms_is_special(op_mode);
			end
			if (wr_misc && rms_is_special(op_mode)) begin
				next_flash_visible = reg_wdata[MISC_FLASH_BIT];
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			config_valid <= 1'b0;
			op_mode <= MODE_RST;
			flash_visible <= FLASH_VIS_RST;
			osc_colpitts_sel <= 1'b0;
			periph_seen <= 1'b0;
			mode_lock <= 1'b0;
		end else begin
			config_valid <= next_config_valid;
			op_mode <= next_op_mode;
			flash_visible <= next_flash_visible;
			osc_colpitts_sel <= next_osc_colpitts_sel;
			periph_seen <= next_periph_seen;
			mode_lock <= next_mode_lock;
		end
	end

	// ------------------------------------------------------------
	// debug monitor activation
	// ------------------------------------------------------------
	rms_dbg_state_t dbg_state;
	rms_dbg_state_t next_dbg_state;

	// active from capture in special single, else after a command
	always_comb begin
		next_dbg_state = dbg_state;
		case (dbg_state)
			DBG_IDLE: begin
				if (debug_activate_cmd) begin
					next_dbg_state = DBG_ACTIVE;
				end else if (cap_pulse && dec_dbg_active) begin
					next_dbg_state = DBG_ACTIVE;
				end
			end
			DBG_ACTIVE: next_dbg_state = DBG_ACTIVE;
			default: next_dbg_state = DBG_IDLE;
		endcase
	end

	// monitor state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dbg_state <= DBG_IDLE;
		end else begin
			dbg_state <= next_dbg_state;
		end
	end

	assign debug_active = (dbg_state == DBG_ACTIVE);

	// ------------------------------------------------------------
	// flash map and register reads
	// ------------------------------------------------------------
	logic next_flash_select;
	logic [DATA_W-1:0] next_reg_rdata;

	// flash answers only while visible
	always_comb begin
		next_flash_select = flash_visible && (cpu_addr >= FLASH_BASE) && (cpu_addr <= FLASH_LAST);
	end

	// read mux, data valid one cycle after the strobe only
	always_comb begin
		next_reg_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_MODE: next_reg_rdata[MODE_W-1:0] = op_mode;
				REG_MISC: next_reg_rdata[MISC_FLASH_BIT] = flash_visible;
				REG_STATUS: begin
					next_reg_rdata[ST_OSC_BIT] = osc_colpitts_sel;
					next_reg_rdata[ST_DBG_BIT] = debug_active;
					next_reg_rdata[ST_VALID_BIT] = config_valid;
					next_reg_rdata[ST_PERIPH_BIT] = periph_seen;
					next_reg_rdata[ST_LOCK_BIT] = mode_lock;
				end
				REG_ID: next_reg_rdata = BLOCK_ID;
				default: next_reg_rdata = '0;
			endcase
		end
	end

	// output registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flash_select <= 1'b0;
			reg_rdata <= '0;
		end else begin
			flash_select <= next_flash_select;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_mode_capture;
		@(posedge clk) disable iff (!nrst)
		cap_pulse |=> op_mode == $past(dec_mode) && config_valid;
	endproperty
	a_mode_capture: assert property (p_mode_capture) else $error("mode bits not taken from straps");

	property p_flash_capture;
		@(posedge clk) disable iff (!nrst)
		cap_pulse |=> flash_visible == rms_flash_decode(op_mode, $past(strap_q.flash));
	endproperty
	a_flash_capture: assert property (p_flash_capture) else $error("flash bit not taken from strap");

	property p_flash_map;
		@(posedge clk) disable iff (!nrst)
		(cpu_addr >= FLASH_BASE) ##1 flash_select |-> $past(flash_visible);
	endproperty
	a_flash_map: assert property (p_flash_map) else $error("flash selected while hidden");

	property p_mode_read;
		@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == REG_MODE |=> reg_rdata[MODE_W-1:0] == $past(op_mode);
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

	property p_mode_change;
		@(posedge clk) disable iff (!nrst)
		!cap_pulse && !rms_is_special(op_mode) && mode_lock |=> $stable(op_mode);
	endproperty
	a_mode_change: assert property (p_mode_change) else $error("locked mode changed");

	property p_special_single;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && {strap_q.top, strap_q.middle, strap_q.bottom} == MODE_SPECIAL_SINGLE
		|=> flash_visible ##1 debug_active;
	endproperty
	a_special_single: assert property (p_special_single) else $error("special single setup wrong");

	property p_dbg_wait;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && !dec_dbg_active && !debug_activate_cmd && !debug_active |=> !debug_active;
	endproperty
	a_dbg_wait: assert property (p_dbg_wait) else $error("monitor active without command");

	property p_dbg_cmd;
		@(posedge clk) disable iff (!nrst)
		debug_activate_cmd |=> debug_active [*2];
	endproperty
	a_dbg_cmd: assert property (p_dbg_cmd) else $error("command did not activate monitor");

	property p_special_test;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && dec_mode == MODE_SPECIAL_TEST |=> !flash_visible;
	endproperty
	a_special_test: assert property (p_special_test) else $error("test mode shows flash");

	property p_emul_narrow;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && dec_mode == MODE_EMUL_NARROW |=> flash_visible == !$past(strap_q.flash);
	endproperty
	a_emul_narrow: assert property (p_emul_narrow) else $error("emulation narrow flash wrong");

	property p_emul_wide;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && dec_mode == MODE_EMUL_WIDE |=> flash_visible != $past(strap_q.flash);
	endproperty
	a_emul_wide: assert property (p_emul_wide) else $error("emulation wide flash wrong");

	property p_normal_single;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && dec_mode == MODE_NORMAL_SINGLE |=> flash_visible && op_mode == MODE_NORMAL_SINGLE;
	endproperty
	a_normal_single: assert property (p_normal_single) else $error("normal single setup wrong");

	property p_normal_expanded;
		@(posedge clk) disable iff (!nrst)
		cap_pulse && (dec_mode == MODE_NORMAL_NARROW || dec_mode == MODE_NORMAL_WIDE)
		|=> flash_visible == $past(strap_q.flash);
	endproperty
	a_normal_expanded: assert property (p_normal_expanded) else $error("normal expanded flash wrong");

	property p_osc_select;
		@(posedge clk) disable iff (!nrst)
		cap_pulse |=> osc_colpitts_sel == $past(strap_q.osc) ##1 $stable(osc_colpitts_sel);
	endproperty
	a_osc_select: assert property (p_osc_select) else $error("oscillator select wrong");

	property p_pulldown_off;
		@(posedge clk) disable iff (!nrst)
		config_valid |-> !pulldown_middle_en && !pulldown_bottom_en;
	endproperty
	a_pulldown_off: assert property (p_pulldown_off) else $error("pull-down on after reset");

endmodule : rms_strap_latch

// ---- tb/rms_strap_board.sv ----
// board model: strap pins held by the board around reset release
`timescale 1ns/1ps
module rms_strap_board
	import rms_pkg::*;
(
	// clock
	input wire logic clk,
	// wanted strap levels
	input wire rms_strap_t cfg,
	input wire logic float_mb,
	// pull-downs from the device
	input wire logic pd_middle,
	input wire logic pd_bottom,
	// strap pins
	output logic top,
	output logic middle,
	output logic bottom,
	output logic flash,
	output logic osc
);
	logic wiggle = 1'b0;

	// an open pin wanders unless a pull-down holds it
	always @(posedge clk) begin
		wiggle <= ~wiggle;
	end

	// straps follow cfg, except middle and bottom while float_mb is set; the bench keeps cfg still across release
	always_comb begin
		top = cfg.top;
		middle = float_mb ? (pd_middle ? 1'b0 : wiggle) : cfg.middle;
		bottom = float_mb ? (pd_bottom ? 1'b0 : ~wiggle) : cfg.bottom;
		flash = cfg.flash;
		osc = cfg.osc;
	end
endmodule : rms_strap_board

// ---- tb/tb_top.sv ----
// testbench: strap capture, mode table, register port and flash map
`timescale 1ns/1ps
module tb_top
	import rms_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	rms_strap_t cfg = '0;
	logic float_mb = 1'b0;
	logic s_top, s_mid, s_bot, s_flash, s_osc;
	logic pd_mid, pd_bot, dbg_cmd = 1'b0, dbg_act;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, d;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [MODE_W-1:0] op_mode;
	logic flash_visible, osc_sel, config_valid, flash_select;
	logic [15:0] cpu_addr = '0;
	int n_fail = 0;
	int check_count = 0;
	// rows: top, middle, bottom, flash strap, osc strap, expected flash bit
	// peripheral levels 1-1-0 never strapped
	localparam logic [5:0] ROWS [11] = '{
		6'b000011,
		6'b001001, 6'b001110,
		6'b010100,
		6'b011011, 6'b011100,
		6'b100011,
		6'b101000, 6'b101111,
		6'b111010, 6'b111101};

	always #10 clk = ~clk;

	rms_strap_board brd (.clk(clk), .cfg(cfg), .float_mb(float_mb), .pd_middle(pd_mid), .pd_bottom(pd_bot),
		.top(s_top), .middle(s_mid), .bottom(s_bot), .flash(s_flash), .osc(s_osc));

	rms_strap_latch uut (.clk(clk), .nrst(nrst), .mode_select_top(s_top), .mode_select_middle(s_mid),
		.mode_select_bottom(s_bot), .flash_map_strap(s_flash), .oscillator_select_strap(s_osc),
		.pulldown_middle_en(pd_mid), .pulldown_bottom_en(pd_bot), .debug_activate_cmd(dbg_cmd),
		.debug_active(dbg_act), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .op_mode(op_mode), .flash_visible(flash_visible), .osc_colpitts_sel(osc_sel),
		.config_valid(config_valid), .cpu_addr(cpu_addr), .flash_select(flash_select));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic final_report();
		if (n_fail == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset(input rms_strap_t s, input logic f);
		@(posedge clk);
		nrst <= 1'b0;
		cfg <= s;
		float_mb <= f;
		#1;
		chk(8'({pd_mid, pd_bot}), 8'h03);
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(8'({pd_mid, pd_bot}), 8'h00);
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic map_chk(input logic [15:0] a, input logic e);
		@(posedge clk);
		cpu_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		chk(8'(flash_select), 8'(e));
	endtask : map_chk

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		for (int i = 0; i < 11; i++) begin
			do_reset(rms_strap_t'(ROWS[i][5:1]), 1'b0);
			chk(8'(op_mode), 8'(ROWS[i][5:3]));
			chk(8'(flash_visible), 8'(ROWS[i][0]));
			chk(8'(osc_sel), 8'(ROWS[i][1]));
			chk(8'(config_valid), 8'h01);
			chk(8'(dbg_act), 8'(ROWS[i][5:3] == 3'h0));
			rd(REG_MODE, d);
			chk(8'(d[2:0]), 8'(ROWS[i][5:3]));
			rd(REG_MISC, d);
			chk(8'(d[0]), 8'(ROWS[i][0]));
			map_chk(16'h4000, ROWS[i][0]);
			map_chk(16'h3fff, 1'b0);
			cfg.flash <= ~cfg.flash;
			cfg.osc <= ~cfg.osc;
			repeat (3) @(posedge clk);
			#1;
			chk(8'({osc_sel, flash_visible}), 8'(ROWS[i][1:0]));
		end
		// open middle and bottom pins read low through the pull-downs
		do_reset(rms_strap_t'(5'b10000), 1'b1);
		chk(8'(op_mode), 8'(MODE_NORMAL_SINGLE));
		chk(8'(dbg_act), 8'h00);
		wr(REG_MISC, 8'h00);
		chk(8'(flash_visible), 8'h01);
		wr(REG_MODE, 8'h05);
		chk(8'(op_mode), 8'h05);
		wr(REG_MODE, 8'h07);
		chk(8'(op_mode), 8'h05);
		rd(REG_STATUS, d);
		chk(d, 8'h14);
		@(posedge clk);
		dbg_cmd <= 1'b1;
		@(posedge clk);
		dbg_cmd <= 1'b0;
		#1;
		chk(8'(dbg_act), 8'h01);
		// special mode: software may hide and show the flash
		do_reset(rms_strap_t'(5'b00010), 1'b0);
		wr(REG_MODE, 8'h02);
		chk(8'(op_mode), 8'h02);
		wr(REG_MISC, 8'h00);
		chk(8'(flash_visible), 8'h00);
		map_chk(16'hffff, 1'b0);
		wr(REG_MISC, 8'h01);
		map_chk(16'hffff, 1'b1);
		rd(REG_STATUS, d);
		chk(d, 8'h06);
		rd(REG_ID, d);
		chk(d, BLOCK_ID);
		@(posedge clk);
		#1;
		chk(reg_rdata, 8'h00);
		rd(8'h10, d);
		chk(d, 8'h00);
		final_report();
	end

	// watchdog on a hung run
	initial begin
		#400000;
		n_fail++;
		final_report();
	end
endmodule : tb_top
